// >>> src/cpusys_pkg.sv
package cpusys_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] ADDR_INT_CTRL = 8'he6;
	localparam logic [7:0] ADDR_FLAGS = 8'he7;
	localparam logic [7:0] ADDR_WP_LOW = 8'he8;
	localparam logic [7:0] ADDR_WP_HIGH = 8'he9;
	localparam logic [7:0] ADDR_GROUP_D_LO = 8'hd0;
	localparam logic [7:0] ADDR_GROUP_D_HI = 8'hdf;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [4:0] RST_INT_CTRL_LO = 5'h07;
	localparam logic [7:0] RST_WP = 8'h00;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int IC_GATE = 4;
	localparam int IC_MODE = 3;
	localparam int FL_C = 7;
	localparam int FL_Z = 6;
	localparam int FL_S = 5;
	localparam int FL_V = 4;
	localparam int FL_DA = 3;
	localparam int FL_H = 2;
	localparam int FL_RSV = 1;
	localparam int FL_DP = 0;
	localparam int WP_MODE = 2;
	localparam int WP_BLK_LSB = 3;
	localparam int NEST_DEPTH = 7;
	// ----------------------------------------
	// core operations driving the flags
	// ----------------------------------------
	typedef enum logic [2:0] {
		CPUSYS_OP_NONE, CPUSYS_OP_ADD, CPUSYS_OP_SUB, CPUSYS_OP_LOGIC, CPUSYS_OP_SHIFT
	} cpusys_alu_op_t;
	typedef enum logic [2:0] {
		CPUSYS_CC_NONE, CPUSYS_CC_SET, CPUSYS_CC_CLR, CPUSYS_CC_CPL
	} cpusys_carry_op_t;
endpackage

// >>> src/cpusys_flag_if.sv
interface cpusys_flag_if;
	import cpusys_pkg::*;
	logic [2:0] op;
	logic word;
	logic [15:0] a;
	logic [15:0] b;
	logic [15:0] res;
	logic cy;
	logic [7:0] flags_in;
	logic [7:0] flags_out;
	modport core (output op, word, a, b, res, cy, flags_in, input flags_out);
	modport calc (input op, word, a, b, res, cy, flags_in, output flags_out);
endinterface

// >>> src/cpusys_flag_calc.sv
module cpusys_flag_calc
	import cpusys_pkg::*;
(
	cpusys_flag_if.calc fi
);
	logic msb_a;
	logic msb_b;
	logic msb_r;
	logic zero;
	always_comb begin
		msb_a = fi.word ? fi.a[15] : fi.a[7];
		msb_b = fi.word ? fi.b[15] : fi.b[7];
		msb_r = fi.word ? fi.res[15] : fi.res[7];
		zero = fi.word ? (fi.res == 16'h0000) : (fi.res[7:0] == 8'h00);
		fi.flags_out = fi.flags_in;
		if (fi.op != CPUSYS_OP_NONE) begin
			fi.flags_out[FL_Z] = zero;
			fi.flags_out[FL_S] = msb_r;
			fi.flags_out[FL_V] = 1'b0;
		end
		case (fi.op)
			CPUSYS_OP_ADD: begin
				fi.flags_out[FL_C] = fi.cy;
				fi.flags_out[FL_V] = (msb_a == msb_b) && (msb_r != msb_a);
				fi.flags_out[FL_DA] = 1'b0;
				fi.flags_out[FL_H] = fi.a[4] ^ fi.b[4] ^ fi.res[4];
			end
			CPUSYS_OP_SUB: begin
				fi.flags_out[FL_C] = fi.cy;
				fi.flags_out[FL_V] = (msb_a != msb_b) && (msb_r != msb_a);
				fi.flags_out[FL_DA] = 1'b1;
				fi.flags_out[FL_H] = fi.a[4] ^ fi.b[4] ^ fi.res[4];
			end
			CPUSYS_OP_SHIFT: fi.flags_out[FL_C] = fi.cy;
			default: ;
		endcase
		fi.flags_out[FL_RSV] = 1'b0;
	end
endmodule // cpusys_flag_calc

// >>> src/cpusys_regs.sv
// Behaviour
// - ack clears gate, return sets it
// - enable/disable instructions set/clear gate
// - gate low blocks all but top level
// - arbitration mode bit software only
// - priority level 000 highest, hw/sw writable
// - requests not outranking level stay pending
// - preemption saves level into nesting store
// - flags saved on interrupt, seven nested copies
// - carry from bit 7 or bit 15
// - set, clear, complement carry instructions
// - zero flag on zero result
// - sign copies result top bit
// - overflow on signed range exceed
// - bcd direction records add or subtract
// - half carry from bit 3
// - memory area flag set/clear by instructions
// - register file as 32 eight-register blocks
// - set instructions choose single or twin mode
// - single mode rounds block down to even
// - twin mode: r0-7 low, r8-15 high
// - group d not directly addressable
// - block number in bits 7:3
// - mode bit 2, bits 1:0 zero
module cpusys_regs
	import cpusys_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_err,
	input wire logic irq_ack,
	input wire logic [2:0] irq_ack_level,
	input wire logic irq_ret,
	input wire logic irq_enable_instr,
	input wire logic irq_mask_instr,
	input wire logic irq_req,
	input wire logic [2:0] irq_req_level,
	input wire logic irq_top_req,
	output logic irq_take,
	output logic arbitration_mode_select,
	output logic [2:0] nesting_priority_store,
	output logic [2:0] nest_level,
	input wire logic [2:0] alu_op,
	input wire logic alu_word,
	input wire logic [15:0] alu_a,
	input wire logic [15:0] alu_b,
	input wire logic [15:0] alu_res,
	input wire logic alu_cy,
	input wire logic [2:0] carry_op,
	input wire logic sdm_instr,
	input wire logic spm_instr,
	output logic memory_area_flag,
	input wire logic set_single_pointer,
	input wire logic set_low_pointer,
	input wire logic set_high_pointer,
	input wire logic [4:0] pointer_block,
	input wire logic [3:0] work_reg,
	output logic [7:0] work_addr
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic global_irq_gate_r;
	logic mode_r;
	logic [2:0] level_r;
	logic [2:0] nest_store_r;
	logic [7:0] flags_r;
	logic [4:0] blk_low_r;
	logic [4:0] blk_high_r;
	logic pointer_mode_bit_r;
	logic [7:0] flag_stack_r [NEST_DEPTH];
	logic [2:0] lvl_stack_r [NEST_DEPTH];
	logic [2:0] depth_r;
	logic [7:0] rdata_nxt;
	logic wr_ok;
	logic ack_push;
	logic ret_pop;
	logic [7:0] flags_alu;
	logic [2:0] depth_m1;
	logic ptr_instr;
	cpusys_flag_if fif ();
	assign fif.op = alu_op;
	assign fif.word = alu_word;
	assign fif.a = alu_a;
	assign fif.b = alu_b;
	assign fif.res = alu_res;
	assign fif.cy = alu_cy;
	assign fif.flags_in = flags_r;
	assign flags_alu = fif.flags_out;
	cpusys_flag_calc u_calc (
		.fi(fif)
	);
	// group d hidden from direct access; a write there pulses reg_err
	assign wr_ok = reg_wr && !(reg_addr >= ADDR_GROUP_D_LO && reg_addr <= ADDR_GROUP_D_HI);
	assign ack_push = irq_ack && (depth_r != 3'(NEST_DEPTH));
	assign ret_pop = irq_ret && (depth_r != 3'h0);
	assign depth_m1 = depth_r - 3'h1;
	assign ptr_instr = set_single_pointer || set_low_pointer || set_high_pointer;
	// ----------------------------------------
	// interrupt control
	// ----------------------------------------
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			global_irq_gate_r <= 1'b0;
		end else if (irq_ack) begin
			global_irq_gate_r <= 1'b0;
		end else if (irq_ret || irq_enable_instr) begin
			global_irq_gate_r <= 1'b1;
		end else if (irq_mask_instr) begin
			global_irq_gate_r <= 1'b0;
		end else if (wr_ok && reg_addr == ADDR_INT_CTRL) begin
			// caller keeps this write away from pending requests
			global_irq_gate_r <= reg_wdata[IC_GATE];
		end
	end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_r <= RST_INT_CTRL_LO[IC_MODE];
		end else if (wr_ok && reg_addr == ADDR_INT_CTRL) begin
			mode_r <= reg_wdata[IC_MODE];
		end
	end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			level_r <= RST_INT_CTRL_LO[2:0];
		end else if (irq_ack) begin
			level_r <= irq_ack_level;
		end else if (ret_pop) begin
			level_r <= lvl_stack_r[depth_m1];
		end else if (wr_ok && reg_addr == ADDR_INT_CTRL) begin
			level_r <= reg_wdata[2:0];
		end
	end
	// store shows the level one below the running one; empty stack shows reset level
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			nest_store_r <= RST_INT_CTRL_LO[2:0];
		end else if (irq_ack) begin
			nest_store_r <= level_r;
		end else if (ret_pop) begin
			nest_store_r <= (depth_m1 == 3'h0) ? RST_INT_CTRL_LO[2:0] : lvl_stack_r[3'(depth_m1 - 3'h1)];
		end
	end
	// a request must outrank the running level; top level ignores the gate
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			irq_take <= 1'b0;
		end else begin
			irq_take <= irq_top_req || (global_irq_gate_r && irq_req && irq_req_level < level_r);
		end
	end
	// ----------------------------------------
	// save stack for flags and levels
	// ----------------------------------------
	// depth reaches seven in either arbitration mode; mode_r does not limit nesting
	// a push into a full stack is dropped; the gate still closes
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			depth_r <= 3'h0;
		end else if (ack_push) begin
			depth_r <= depth_r + 3'h1;
		end else if (ret_pop) begin
			depth_r <= depth_m1;
		end
	end
	for (genvar i = 0; i < NEST_DEPTH; i++) begin : g_stack
		always_ff @(posedge mclk or posedge sys_rst) begin
			if (sys_rst) begin
				flag_stack_r[i] <= RST_FLAGS;
				lvl_stack_r[i] <= RST_INT_CTRL_LO[2:0];
			end else if (ack_push && depth_r == 3'(i)) begin
				flag_stack_r[i] <= flags_r;
				lvl_stack_r[i] <= level_r;
			end
		end
	end
	// ----------------------------------------
	// condition flags
	// ----------------------------------------
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			flags_r <= RST_FLAGS;
		end else if (ret_pop) begin
			flags_r <= flag_stack_r[depth_m1];
		end else if (wr_ok && reg_addr == ADDR_FLAGS) begin
			flags_r <= {reg_wdata[7:2], 1'b0, reg_wdata[0]};
		end else if (carry_op == CPUSYS_CC_SET) begin
			flags_r[FL_C] <= 1'b1;
		end else if (carry_op == CPUSYS_CC_CLR) begin
			flags_r[FL_C] <= 1'b0;
		end else if (carry_op == CPUSYS_CC_CPL) begin
			flags_r[FL_C] <= ~flags_r[FL_C];
		end else if (sdm_instr) begin
			flags_r[FL_DP] <= 1'b1;
		end else if (spm_instr) begin
			flags_r[FL_DP] <= 1'b0;
		end else begin
			flags_r <= flags_alu;
		end
	end
	// ----------------------------------------
	// working register pointers
	// ----------------------------------------
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			blk_low_r <= RST_WP[7:3];
		end else if (set_single_pointer || set_low_pointer) begin
			blk_low_r <= pointer_block;
		end else if (!ptr_instr && wr_ok && reg_addr == ADDR_WP_LOW) begin
			blk_low_r <= reg_wdata[7:3];
		end
	end
	// single or low instruction wins over high in the same cycle
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			blk_high_r <= RST_WP[7:3];
		end else if (set_high_pointer && !set_single_pointer && !set_low_pointer) begin
			blk_high_r <= pointer_block;
		end else if (!ptr_instr && wr_ok && reg_addr == ADDR_WP_HIGH) begin
			blk_high_r <= reg_wdata[7:3];
		end
	end
	// one mode bit shared by both pointers, so either write changes it
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			pointer_mode_bit_r <= RST_WP[WP_MODE];
		end else if (set_single_pointer) begin
			pointer_mode_bit_r <= 1'b0;
		end else if (set_low_pointer || set_high_pointer) begin
			pointer_mode_bit_r <= 1'b1;
		end else if (wr_ok && (reg_addr == ADDR_WP_LOW || reg_addr == ADDR_WP_HIGH)) begin
			pointer_mode_bit_r <= reg_wdata[WP_MODE];
		end
	end
	// 32 blocks of eight: block number is the address top five bits
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			work_addr <= 8'h00;
		end else if (!pointer_mode_bit_r) begin
			work_addr <= {blk_low_r[4:1], work_reg};
		end else begin
			work_addr <= {work_reg[3] ? blk_high_r : blk_low_r, work_reg[2:0]};
		end
	end
	// ----------------------------------------
	// read port
	// ----------------------------------------
	always_comb begin
		case (reg_addr)
			ADDR_INT_CTRL: rdata_nxt = {3'h0, global_irq_gate_r, mode_r, level_r};
			ADDR_FLAGS: rdata_nxt = flags_r;
			ADDR_WP_LOW: rdata_nxt = {blk_low_r, pointer_mode_bit_r, 2'h0};
			ADDR_WP_HIGH: rdata_nxt = {blk_high_r, pointer_mode_bit_r, 2'h0};
			default: rdata_nxt = 8'h00;
		endcase
	end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= rdata_nxt;
		end
	end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_err <= 1'b0;
		end else begin
			reg_err <= reg_wr && !wr_ok;
		end
	end
	// ----------------------------------------
	// state mirrors
	// ----------------------------------------
	// every output is a flop; mirrors lag their state by one cycle
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			arbitration_mode_select <= 1'b0;
		end else begin
			arbitration_mode_select <= mode_r;
		end
	end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			nesting_priority_store <= 3'h0;
		end else begin
			nesting_priority_store <= nest_store_r;
		end
	end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			nest_level <= 3'h0;
		end else begin
			nest_level <= depth_r;
		end
	end
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			memory_area_flag <= 1'b0;
		end else begin
			memory_area_flag <= flags_r[FL_DP];
		end
	end
endmodule // cpusys_regs

// >>> bench/cpusys_regs_properties.sv
module cpusys_regs_chk
	import cpusys_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_err,
	input wire logic irq_ack,
	input wire logic [2:0] irq_ack_level,
	input wire logic irq_ret,
	input wire logic irq_top_req,
	input wire logic irq_take,
	input wire logic [2:0] carry_op,
	input wire logic [2:0] nesting_priority_store,
	input wire logic [2:0] nest_level,
	input wire logic sdm_instr,
	input wire logic spm_instr,
	input wire logic memory_area_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	wire logic grp_d = reg_wr && reg_addr[7:4] == 4'hd;
	// a flag write, carry instruction or return at the same edge outranks the area flag
	wire logic fl_busy = irq_ret || carry_op != CPUSYS_CC_NONE || (reg_wr && reg_addr == ADDR_FLAGS);
	chk_err_on_d: assert property (grp_d |=> reg_err) else $error("group d write not refused");
	chk_err_only_d: assert property (!grp_d |=> !reg_err) else $error("stray write error");
	chk_rd_unmapped: assert property (!(reg_addr inside {[ADDR_INT_CTRL:ADDR_WP_HIGH]}) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_top_take: assert property (irq_top_req |=> irq_take) else $error("top request not taken");
	chk_gate_block: assert property (irq_ack ##1 !irq_top_req |=> !irq_take) else $error("taken with gate off");
	chk_nest_save: assert property (irq_ack ##1 irq_ack |-> ##2 nesting_priority_store == $past(irq_ack_level, 3))
		else $error("prior level not saved");
	chk_nest_push: assert property (irq_ack ##1 nest_level != 3'd7
		|=> nest_level == $past(nest_level) + 3'd1) else $error("stack depth not raised");
	chk_nest_pop: assert property (irq_ret && !irq_ack ##1 nest_level != 3'd0
		|=> nest_level == $past(nest_level) - 3'd1) else $error("stack depth not lowered");
	chk_area_set: assert property (sdm_instr && !fl_busy |-> ##2 memory_area_flag) else $error("area flag not set");
	chk_area_clr: assert property (spm_instr && !sdm_instr && !fl_busy |-> ##2 !memory_area_flag)
		else $error("area flag not cleared");
	cov_double_ack: cover property (irq_ack ##1 irq_ack);
	cov_refused: cover property (reg_err);
	cov_top: cover property (irq_top_req ##1 irq_take);
endmodule // cpusys_regs_chk

bind cpusys_regs cpusys_regs_chk cpusys_regs_chk_inst (.mclk, .sys_rst, .reg_wr, .reg_addr, .reg_rdata, .reg_err,
	.irq_ack, .irq_ack_level, .irq_ret, .irq_top_req, .irq_take, .carry_op, .nesting_priority_store, .nest_level,
	.sdm_instr, .spm_instr, .memory_area_flag);

// >>> bench/cpusys_regs_tb.sv
module cpusys_regs_tb
	import cpusys_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, sys_rst, reg_wr, irq_ack, irq_ret, irq_enable_instr, irq_mask_instr, irq_req, irq_top_req;
	logic alu_word, alu_cy, sdm_instr, spm_instr, set_single_pointer, set_low_pointer, set_high_pointer;
	logic reg_err, irq_take, arbitration_mode_select, memory_area_flag;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, work_addr;
	logic [2:0] irq_ack_level, irq_req_level, nesting_priority_store, nest_level, alu_op, carry_op;
	logic [15:0] alu_a, alu_b, alu_res;
	logic [4:0] pointer_block;
	logic [3:0] work_reg;
	int n_errors = 0;
	int total_checks = 0;
	// op, word, a, b, result, carry, expected flags
	logic [67:0] alu_t [6] = '{68'h1_0_007f_0001_0080_0_34, 68'h2_0_0000_0001_00ff_1_ac,
		68'h1_1_8000_8000_0000_1_d0, 68'h2_0_0080_0001_007f_0_1c, 68'h4_0_0081_0000_0002_1_80,
		68'h3_1_ffff_8000_8000_1_20};
	logic [2:0] c_op [4] = '{CPUSYS_CC_SET, CPUSYS_CC_CPL, CPUSYS_CC_CPL, CPUSYS_CC_CLR};
	logic [7:0] c_exp [4] = '{8'hfd, 8'h7d, 8'hfd, 8'h7d};

	cpusys_regs cpusys_regs_inst (.mclk, .sys_rst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .reg_err, .irq_ack,
		.irq_ack_level, .irq_ret, .irq_enable_instr, .irq_mask_instr, .irq_req, .irq_req_level, .irq_top_req, .irq_take,
		.arbitration_mode_select, .nesting_priority_store, .nest_level, .alu_op, .alu_word, .alu_a, .alu_b, .alu_res,
		.alu_cy, .carry_op, .sdm_instr, .spm_instr, .memory_area_flag, .set_single_pointer, .set_low_pointer,
		.set_high_pointer, .pointer_block, .work_reg, .work_addr);

	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick();
		@(negedge mclk);
	endtask
	// strobe held one cycle, then a gap so back-to-back calls never re-drive in one step
	task automatic wr(logic [7:0] a, logic [7:0] d, logic e);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		tick();
		reg_wr = 1'b0;
		chk("reg_err", reg_err, e);
		tick();
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		reg_addr = a;
		tick();
		chk("reg_rdata", reg_rdata, e);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick();
		s = 1'b0;
		tick();
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial begin
		repeat (5000) @(posedge mclk);
		n_errors++;
		stop_test();
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		sys_rst = 1'b1;
		{reg_wr, reg_addr, reg_wdata, irq_ack, irq_ack_level, irq_ret, irq_enable_instr, irq_mask_instr, irq_req,
			irq_req_level, irq_top_req, alu_op, alu_word, alu_a, alu_b, alu_res, alu_cy, carry_op, sdm_instr,
			spm_instr, set_single_pointer, set_low_pointer, set_high_pointer, pointer_block, work_reg} = '0;
		repeat (2) @(posedge mclk);
		tick();
		sys_rst = 1'b0;
		rd(ADDR_FLAGS, RST_FLAGS);
		rd(ADDR_INT_CTRL, {3'h0, RST_INT_CTRL_LO});
		rd(8'he0, 8'h00);
		$display("test reset done");
		wr(ADDR_FLAGS, 8'hff, 1'b0);
		rd(ADDR_FLAGS, 8'hfd);
		chk("memory_area_flag", memory_area_flag, 1'b1);
		wr(ADDR_FLAGS, 8'h7d, 1'b0);
		foreach (c_op[i]) begin
			carry_op = c_op[i];
			tick();
			carry_op = CPUSYS_CC_NONE;
			rd(ADDR_FLAGS, c_exp[i]);
		end
		foreach (alu_t[i]) begin
			wr(ADDR_FLAGS, 8'h00, 1'b0);
			{alu_op, alu_word, alu_a, alu_b, alu_res, alu_cy} = {alu_t[i][66:64], alu_t[i][60], alu_t[i][59:12], alu_t[i][8]};
			tick();
			alu_op = CPUSYS_OP_NONE;
			rd(ADDR_FLAGS, alu_t[i][7:0]);
		end
		$display("test flags done");
		// control written only with nothing pending
		wr(ADDR_INT_CTRL, 8'h1d, 1'b0);
		chk("arbitration_mode_select", arbitration_mode_select, 1'b1);
		wr(ADDR_INT_CTRL, 8'h15, 1'b0);
		rd(ADDR_INT_CTRL, 8'h15);
		irq_req = 1'b1;
		for (int i = 4; i < 7; i++) begin
			irq_req_level = i[2:0];
			tick();
			chk("irq_take", irq_take, i == 4);
		end
		wr(ADDR_FLAGS, 8'h81, 1'b0);
		irq_req_level = 3'd0;
		irq_ack = 1'b1;
		irq_ack_level = 3'd4;
		tick();
		irq_ack_level = 3'd2;
		tick();
		irq_ack = 1'b0;
		tick();
		chk("irq_take", irq_take, 1'b0);
		chk("nesting_priority_store", nesting_priority_store, 3'd4);
		chk("nest_level", nest_level, 3'd2);
		rd(ADDR_INT_CTRL, 8'h02);
		irq_top_req = 1'b1;
		tick();
		chk("irq_take", irq_take, 1'b1);
		{irq_top_req, irq_req} = 2'b00;
		wr(ADDR_FLAGS, 8'h40, 1'b0);
		pulse(irq_ret);
		rd(ADDR_FLAGS, 8'h81);
		rd(ADDR_INT_CTRL, 8'h14);
		pulse(irq_ret);
		rd(ADDR_INT_CTRL, 8'h15);
		chk("nest_level", nest_level, 3'd0);
		pulse(irq_mask_instr);
		rd(ADDR_INT_CTRL, 8'h05);
		pulse(irq_enable_instr);
		rd(ADDR_INT_CTRL, 8'h15);
		pulse(spm_instr);
		chk("memory_area_flag", memory_area_flag, 1'b0);
		pulse(sdm_instr);
		chk("memory_area_flag", memory_area_flag, 1'b1);
		$display("test interrupt done");
		pointer_block = 5'd3;
		pulse(set_single_pointer);
		work_reg = 4'hf;
		tick();
		chk("work_addr", work_addr, 8'h1f);
		rd(ADDR_WP_LOW, {5'd3, 3'd0});
		pointer_block = 5'd5;
		pulse(set_low_pointer);
		pointer_block = 5'd30;
		pulse(set_high_pointer);
		work_reg = 4'h2;
		tick();
		chk("work_addr", work_addr, 8'h2a);
		work_reg = 4'h9;
		tick();
		chk("work_addr", work_addr, 8'hf1);
		rd(ADDR_WP_LOW, 8'h2c);
		rd(ADDR_WP_HIGH, 8'hf4);
		wr(ADDR_WP_LOW, 8'hff, 1'b0);
		rd(ADDR_WP_LOW, 8'hfc);
		work_reg = 4'h7;
		tick();
		chk("work_addr", work_addr, 8'hff);
		$display("test pointers done");
		wr(ADDR_GROUP_D_LO, 8'h5a, 1'b1);
		wr(ADDR_GROUP_D_HI, 8'ha5, 1'b1);
		rd(ADDR_GROUP_D_LO, 8'h00);
		$display("test group d done");
		sys_rst = 1'b1;
		tick();
		sys_rst = 1'b0;
		rd(ADDR_INT_CTRL, {3'h0, RST_INT_CTRL_LO});
		rd(ADDR_WP_LOW, RST_WP);
		rd(ADDR_FLAGS, RST_FLAGS);
		chk("memory_area_flag", memory_area_flag, 1'b0);
		$display("test mid reset done");
		stop_test();
	end
endmodule // cpusys_regs_tb
